/* sdm_duplex_ctrl.sv */
// line mode control for two differential serial channels
`timescale 1ns/10ps
module sdm_duplex_ctrl
    import sdm_pkg::*;
#(
    parameter int W         = 8,
    parameter int FLASH_LEN = FLASH_CYC
)
(
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    input  wire sdm_run_e            run_state,
    input  wire logic [NUM_CH-1:0]   cfg_echo_sup,
    input  wire logic [NUM_CH-1:0]   cfg_p2p_mode_en,
    input  wire logic [NUM_CH-1:0]   tx_busy,
    input  wire logic [NUM_CH-1:0]   tx_queue_empty,
    input  wire logic [NUM_CH-1:0]   rx_line_active,
    input  wire logic [NUM_CH-1:0]   rx_in_valid,
    input  wire logic [NUM_CH*W-1:0] rx_in_data,
    output logic      [NUM_CH-1:0]   rx_in_ready,
    output logic      [NUM_CH-1:0]   rx_out_valid,
    output logic      [NUM_CH*W-1:0] rx_out_data,
    input  wire logic [NUM_CH-1:0]   rx_out_ready,
    output logic      [NUM_CH-1:0]   act_p2p,
    output logic      [NUM_CH-1:0]   act_echo_sup,
    output logic                     run_led,
    output logic                     tx_activity_ch1,
    output logic                     rx_activity_ch1,
    output logic                     tx_activity_ch2,
    output logic                     rx_activity_ch2
);
    // synchronised line activity
    logic [NUM_CH-1:0] rxa_s1;
    logic [NUM_CH-1:0] rxa_s2;
    // active settings
    logic [NUM_CH-1:0] p2p;
    logic [NUM_CH-1:0] echo;
    logic [NUM_CH-1:0] next_p2p;
    logic [NUM_CH-1:0] next_echo;
    // receive lockout after transmit
    logic [NUM_CH-1:0] lock;
    logic [NUM_CH-1:0] next_lock;
    // two entry buffers
    logic [W-1:0]      mem [NUM_CH][2];
    logic [W-1:0]      next_mem [NUM_CH][2];
    logic [1:0]        cnt [NUM_CH];
    logic [1:0]        next_cnt [NUM_CH];
    logic [NUM_CH-1:0] accept;
    logic [NUM_CH-1:0] next_in_ready;
    logic [NUM_CH-1:0] next_out_valid;
    logic [NUM_CH*W-1:0] next_out_data;
    // run light
    logic [31:0]       tick;
    logic [31:0]       next_tick;
    logic [2:0]        phase;
    logic [2:0]        next_phase;
    logic              next_run_led;
    logic [3:0]        next_act;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rxa_s1 <= '0;
            rxa_s2 <= '0;
        end
        else
        begin
            rxa_s1 <= rx_line_active;
            rxa_s2 <= rxa_s1;
        end
    end

    // settings, lockout and receive gating
    always_comb
    begin
        for (int c = 0; c < NUM_CH; c++)
        begin
            next_p2p[c]  = p2p[c];
            next_echo[c] = echo[c];
            // setting entry 8000h:06h drives cfg_echo_sup
            if (!tx_busy[c] && tx_queue_empty[c] && !rxa_s2[c])
            begin
                next_p2p[c]  = cfg_p2p_mode_en[c];
                next_echo[c] = cfg_echo_sup[c];
            end
            // receiver held off until last queued word has gone out
            next_lock[c] = p2p[c] && echo[c] && !(tx_queue_empty[c] && !tx_busy[c]);
            if (p2p[c])
                // full duplex: receive while sending unless locked out by echo suppression
                accept[c] = !lock[c];
            else if (echo[c])
                // bus: own echo dropped while sending
                accept[c] = !tx_busy[c];
            else
                // bus without suppression: echo passes too
                accept[c] = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            p2p  <= '0;
            echo <= '0;
            lock <= '0;
        end
        else
        begin
            p2p  <= next_p2p;
            echo <= next_echo;
            lock <= next_lock;
        end
    end

    // buffers: dropped words are taken but not stored
    always_comb
    begin
        for (int c = 0; c < NUM_CH; c++)
        begin
            logic push;
            logic pop;
            push = 1'b0;
            pop  = 1'b0;
            next_mem[c][0] = mem[c][0];
            next_mem[c][1] = mem[c][1];
            next_cnt[c]    = cnt[c];
            pop  = rx_out_valid[c] && rx_out_ready[c];
            push = rx_in_valid[c] && rx_in_ready[c] && accept[c];
            if (pop)
            begin
                next_mem[c][0] = mem[c][1];
                next_cnt[c]    = cnt[c] - 2'h1;
            end
            if (push)
            begin
                next_mem[c][pop ? 32'(cnt[c]) - 1 : 32'(cnt[c])] = rx_in_data[c*W +: W];
                next_cnt[c] = next_cnt[c] + 2'h1;
            end
            next_in_ready[c]  = next_cnt[c] < BUF_DEPTH;
            next_out_valid[c] = next_cnt[c] != 2'h0;
            next_out_data[c*W +: W] = next_mem[c][0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                cnt[c]    <= 2'h0;
                mem[c][0] <= '0;
                mem[c][1] <= '0;
            end
            rx_in_ready  <= '0;
            rx_out_valid <= '0;
            rx_out_data  <= '0;
        end
        else
        begin
            cnt          <= next_cnt;
            mem          <= next_mem;
            rx_in_ready  <= next_in_ready;
            rx_out_valid <= next_out_valid;
            rx_out_data  <= next_out_data;
        end
    end

    // run light pattern
    always_comb
    begin
        next_tick  = tick + 32'h1;
        next_phase = phase;
        if (tick >= 32'(FLASH_LEN - 1))
        begin
            next_tick  = 32'h0;
            next_phase = (phase >= 3'(SINGLE_OFF_MULT)) ? 3'h0 : phase + 3'h1;
        end
        case (run_state)
            SDM_INIT:   next_run_led = 1'b0;
            SDM_BOOT:   next_run_led = 1'b0;
            SDM_PREOP:  next_run_led = !phase[0];
            SDM_SAFEOP: next_run_led = phase == 3'h0;
            SDM_OP:     next_run_led = 1'b1;
            default:    next_run_led = 1'b0;
        endcase
        next_act = {rxa_s2[1], tx_busy[1], rxa_s2[0], tx_busy[0]};
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            tick            <= 32'h0;
            phase           <= 3'h0;
            run_led         <= 1'b0;
            tx_activity_ch1 <= 1'b0;
            rx_activity_ch1 <= 1'b0;
            tx_activity_ch2 <= 1'b0;
            rx_activity_ch2 <= 1'b0;
            act_p2p         <= '0;
            act_echo_sup    <= '0;
        end
        else
        begin
            tick            <= next_tick;
            phase           <= next_phase;
            run_led         <= next_run_led;
            tx_activity_ch1 <= next_act[0];
            rx_activity_ch1 <= next_act[1];
            tx_activity_ch2 <= next_act[2];
            rx_activity_ch2 <= next_act[3];
            act_p2p         <= next_p2p;
            act_echo_sup    <= next_echo;
        end
    end

    chk_op_led_on: assert property (@(posedge mclk) disable iff (sys_rst)
        run_state == SDM_OP |=> run_led)
        else $error("run light not on in op");
    chk_init_led_off: assert property (@(posedge mclk) disable iff (sys_rst)
        run_state == SDM_INIT |=> !run_led)
        else $error("run light not off in init");
    chk_boot_led_off: assert property (@(posedge mclk) disable iff (sys_rst)
        run_state == SDM_BOOT |=> !run_led)
        else $error("run light not off in boot");

    chk_tx_light: assert property (@(posedge mclk) disable iff (sys_rst)
        tx_busy[0] |=> tx_activity_ch1)
        else $error("tx light ch1 missing");
    chk_tx_light2: assert property (@(posedge mclk) disable iff (sys_rst)
        tx_busy[1] |=> tx_activity_ch2)
        else $error("tx light ch2 missing");
    chk_tx_dark: assert property (@(posedge mclk) disable iff (sys_rst)
        !tx_busy[0] |=> !tx_activity_ch1)
        else $error("tx light ch1 lit while idle");
    chk_rx_light: assert property (@(posedge mclk) disable iff (sys_rst)
        rx_line_active[0] [*3] |=> rx_activity_ch1)
        else $error("rx light ch1 missing");
    chk_rx_light2: assert property (@(posedge mclk) disable iff (sys_rst)
        rx_line_active[1] [*3] |=> rx_activity_ch2)
        else $error("rx light ch2 missing");
    chk_rx_dark: assert property (@(posedge mclk) disable iff (sys_rst)
        !rx_line_active[0] [*3] |=> !rx_activity_ch1)
        else $error("rx light ch1 lit while line idle");

    chk_echo_drop: assert property (@(posedge mclk) disable iff (sys_rst)
        !p2p[0] && echo[0] && tx_busy[0] && rx_in_valid[0] && rx_in_ready[0]
        |=> cnt[0] <= $past(cnt[0]))
        else $error("own echo stored");
    chk_echo_drop1: assert property (@(posedge mclk) disable iff (sys_rst)
        !p2p[1] && echo[1] && tx_busy[1] && rx_in_valid[1] && rx_in_ready[1]
        |=> cnt[1] <= $past(cnt[1]))
        else $error("word stored while ch2 sends");
    chk_lock_drop: assert property (@(posedge mclk) disable iff (sys_rst)
        p2p[0] && lock[0] && rx_in_valid[0] && rx_in_ready[0] && !rx_out_ready[0]
        |=> cnt[0] == $past(cnt[0]))
        else $error("word stored while locked");
    chk_bus_keep: assert property (@(posedge mclk) disable iff (sys_rst)
        !p2p[0] && !echo[0] && rx_in_valid[0] && rx_in_ready[0] && !rx_out_ready[0]
        |=> cnt[0] == $past(cnt[0]) + 2'h1)
        else $error("bus word lost");
    chk_duplex_keep: assert property (@(posedge mclk) disable iff (sys_rst)
        p2p[0] && !echo[0] && rx_in_valid[0] && rx_in_ready[0] && !rx_out_ready[0]
        |=> cnt[0] == $past(cnt[0]) + 2'h1)
        else $error("full duplex word lost");
    chk_lock_set: assert property (@(posedge mclk) disable iff (sys_rst)
        p2p[0] && echo[0] && tx_busy[0] |=> lock[0])
        else $error("receiver not locked while sending");
    chk_lock_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        p2p[0] && echo[0] && !tx_busy[0] && tx_queue_empty[0] |=> !lock[0])
        else $error("receiver still locked after sending");

    chk_idle_apply: assert property (@(posedge mclk) disable iff (sys_rst)
        tx_busy[0] |=> $stable(p2p[0]) && $stable(echo[0]))
        else $error("setting changed while busy");
    chk_settings_apply: assert property (@(posedge mclk) disable iff (sys_rst)
        !tx_busy[0] && tx_queue_empty[0] && !rxa_s2[0]
        |=> p2p[0] == $past(cfg_p2p_mode_en[0]) && echo[0] == $past(cfg_echo_sup[0]))
        else $error("setting not applied while idle");
    chk_buf_bound: assert property (@(posedge mclk) disable iff (sys_rst)
        cnt[0] <= BUF_DEPTH && ($past(sys_rst) || rx_in_ready[0] == (cnt[0] < BUF_DEPTH)))
        else $error("buffer count bad");

    cov_full_duplex: cover property (@(posedge mclk) p2p[0] && tx_busy[0] && rx_out_valid[0]);
    cov_bus_echo: cover property (@(posedge mclk) !p2p[0] && !echo[0] && tx_busy[0]
        && rx_in_valid[0]);
    cov_buf_full: cover property (@(posedge mclk) cnt[0] == BUF_DEPTH);
    cov_lockout: cover property (@(posedge mclk) lock[1] ##1 !lock[1]);
    cov_safeop_flash: cover property (@(posedge mclk) run_state == SDM_SAFEOP
        && run_led);
endmodule

/* sdm_pkg.sv */
// package with constants and types for the serial duplex mode control
package sdm_pkg;
    localparam int          NUM_CH          = 2;
    localparam int          CLK_MHZ         = 250;
    localparam int          FLASH_MS        = 200;
    localparam int          FLASH_CYC       = CLK_MHZ * 1000 * FLASH_MS;
    localparam int          SINGLE_OFF_MULT = 5;
    localparam logic [15:0] SET_INDEX       = 16'h8000;
    localparam logic [7:0]  SET_SUB_ECHO    = 8'h06;
    localparam logic [1:0]  BUF_DEPTH       = 2'h2;

    typedef enum logic [2:0]
    {
        SDM_INIT,
        SDM_BOOT,
        SDM_PREOP,
        SDM_SAFEOP,
        SDM_OP
    } sdm_run_e;
endpackage

/* sdm_remote.sv */
// remote serial device model that sends words to the receive path
`timescale 1ns/10ps
module sdm_remote
    import sdm_pkg::*;
#(
    parameter int W = 8
)
(
    input  wire logic                mclk,
    input  wire logic [NUM_CH-1:0]   rx_in_ready,
    output logic      [NUM_CH-1:0]   rx_in_valid,
    output logic      [NUM_CH*W-1:0] rx_in_data,
    output logic      [NUM_CH-1:0]   rx_line_active
);
    initial
    begin
        rx_in_valid    = '0;
        rx_in_data     = '0;
        rx_line_active = '0;
    end
    // line goes busy first, word held until taken or 50 cycles pass, released data is inverted
    task automatic send(input int ch, input logic [W-1:0] d);
        int n;
        n = 0;
        @(negedge mclk);
        rx_line_active[ch] = 1'b1;
        repeat (4) @(negedge mclk);
        rx_in_valid[ch]     = 1'b1;
        rx_in_data[ch*W+:W] = d;
        while (rx_in_ready[ch] !== 1'b1 && n < 50)
        begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        rx_in_valid[ch]     = 1'b0;
        rx_in_data[ch*W+:W] = ~d;
        rx_line_active[ch]  = 1'b0;
    endtask
endmodule

/* tb.sv */
// testbench for the serial duplex mode control
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb
    import sdm_pkg::*;
;
    logic            mclk = 1'b0;
    logic            sys_rst = 1'b1;
    sdm_run_e        run_state = SDM_INIT;
    logic [1:0]      cfg_echo_sup = '0;
    logic [1:0]      cfg_p2p_mode_en = '0;
    logic [1:0]      tx_busy = '0;
    logic [1:0]      tx_queue_empty = '1;
    logic [1:0]      rx_out_ready = '0;
    logic [1:0]      rx_line_active;
    logic [1:0]      rx_in_valid;
    logic [15:0]     rx_in_data;
    logic [1:0]      rx_in_ready;
    logic [1:0]      rx_out_valid;
    logic [15:0]     rx_out_data;
    logic [1:0]      act_p2p;
    logic [1:0]      act_echo_sup;
    logic            run_led;
    logic [1:0]      txa;
    logic [1:0]      rxa;
    int              err_total = 0;
    int              num_checks = 0;
    int              ch;
    logic            k;
    logic [7:0]      d;
    logic [7:0]      d2;
    int              n;
    localparam int   FL = 4;

    always #2 mclk = ~mclk;

    sdm_remote rem_u (.mclk(mclk), .rx_in_ready(rx_in_ready), .rx_in_valid(rx_in_valid),
        .rx_in_data(rx_in_data), .rx_line_active(rx_line_active));

    sdm_duplex_ctrl #(.W(8), .FLASH_LEN(FL)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
        .run_state(run_state), .cfg_echo_sup(cfg_echo_sup),
        .cfg_p2p_mode_en(cfg_p2p_mode_en), .tx_busy(tx_busy),
        .tx_queue_empty(tx_queue_empty), .rx_line_active(rx_line_active),
        .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data), .rx_in_ready(rx_in_ready),
        .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data),
        .rx_out_ready(rx_out_ready), .act_p2p(act_p2p), .act_echo_sup(act_echo_sup),
        .run_led(run_led), .tx_activity_ch1(txa[0]), .rx_activity_ch1(rxa[0]),
        .tx_activity_ch2(txa[1]), .rx_activity_ch2(rxa[1]));

    // expected keep or drop of a received word
    function automatic logic exp_keep(input logic e, input logic p, input logic b,
                                      input logic q);
        if (!e)
            return 1'b1;
        if (p)
            return !b && q;
        return !b;
    endfunction

    // expected lit cycles of the run light over one whole pattern
    function automatic int exp_lit(input sdm_run_e s, input int len);
        case (s)
            SDM_PREOP:  return len * ((SINGLE_OFF_MULT + 2) / 2);
            SDM_SAFEOP: return len;
            default:    return 0;
        endcase
    endfunction

    // counts lit cycles of the run light over one whole pattern
    task automatic count_lit(input sdm_run_e s, output int n_lit);
        run_state = s;
        repeat (2) @(negedge mclk);
        n_lit = 0;
        repeat (FL * (SINGLE_OFF_MULT + 1))
        begin
            @(negedge mclk);
            if (run_led === 1'b1)
                n_lit++;
        end
    endtask

    task automatic drain(input int c);
        @(negedge mclk);
        rx_out_ready[c] = 1'b1;
        @(negedge mclk);
        rx_out_ready[c] = 1'b0;
    endtask

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #40000;
        err_total++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(32'h4c6e));
        repeat (3) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (4) @(negedge mclk);
        `CHK(run_led, 1'b0)
        run_state = SDM_OP;
        repeat (4) @(negedge mclk);
        `CHK(run_led, 1'b1)
        for (int m = 0; m < 8; m++)
        begin
            tx_busy         = '0;
            tx_queue_empty  = '1;
            cfg_echo_sup    = {2{m[1]}};
            cfg_p2p_mode_en = {2{m[0]}};
            repeat (6) @(negedge mclk);
            `CHK(act_echo_sup, cfg_echo_sup)
            `CHK(act_p2p, cfg_p2p_mode_en)
            tx_busy        = {2{m[2]}};
            tx_queue_empty = {2{~m[2]}};
            repeat (3) @(negedge mclk);
            `CHK(txa, tx_busy)
            if (m[2])
            begin
                cfg_p2p_mode_en = ~cfg_p2p_mode_en;
                repeat (5) @(negedge mclk);
                `CHK(act_p2p, {2{m[0]}})
                cfg_p2p_mode_en = ~cfg_p2p_mode_en;
            end
            ch = $urandom % 2;
            d  = 8'($urandom);
            k  = exp_keep(m[1], m[0], m[2], ~m[2]);
            fork
                rem_u.send(ch, d);
                begin
                    repeat (4) @(negedge mclk);
                    `CHK(rxa[ch], 1'b1)
                end
            join
            repeat (3) @(negedge mclk);
            `CHK(rx_out_valid[ch], k)
            if (k)
                `CHK(rx_out_data[ch*8+:8], d)
            drain(ch);
            `CHK(rx_out_valid[ch], 1'b0)
        end
        tx_busy        = '0;
        tx_queue_empty = '1;
        cfg_echo_sup   = '0;
        repeat (6) @(negedge mclk);
        d  = 8'($urandom);
        d2 = 8'h5A;
        rem_u.send(0, d);
        rem_u.send(0, d2);
        repeat (3) @(negedge mclk);
        `CHK(rx_in_ready[0], 1'b0)
        `CHK(rx_out_data[7:0], d)
        drain(0);
        `CHK(rx_out_data[7:0], d2)
        drain(0);
        `CHK(rx_out_valid[0], 1'b0)
        d = 8'($urandom);
        rem_u.send(1, d);
        `CHK(rx_out_valid[1], 1'b1)
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        `CHK(rx_out_valid, 2'h0)
        `CHK(rx_in_ready, 2'h0)
        sys_rst = 1'b0;
        @(negedge mclk);
        `CHK(rx_in_ready, 2'h3)
        rem_u.send(1, d2);
        repeat (3) @(negedge mclk);
        `CHK(rx_out_data[15:8], d2)
        drain(1);
        `CHK(rx_out_valid[1], 1'b0)
        count_lit(SDM_PREOP, n);
        `CHK(n, exp_lit(SDM_PREOP, FL))
        count_lit(SDM_SAFEOP, n);
        `CHK(n, exp_lit(SDM_SAFEOP, FL))
        count_lit(SDM_BOOT, n);
        `CHK(n, exp_lit(SDM_BOOT, FL))
        report_and_stop();
    end
endmodule
